// file: rtl/stream_source.v
// Streaming source: two-entry buffer feeding a ready-latency stream link
`include "stream_source_defs.vh"
module stream_source #(
  parameter DATA_W = `SRC_DATA_W,
  parameter CHAN_W = `SRC_CHAN_W,
  parameter HIGHEST_CHANNEL = `SRC_HIGHEST_CHANNEL,
  parameter ERR_W = `SRC_ERR_W,
  parameter EMPTY_W = `SRC_EMPTY_W,
  parameter READY_LATENCY = `SRC_READY_LATENCY
) (
  input wire core_clk_i,
  input wire rstn_i,
  input wire usr_valid_i,
  input wire [DATA_W-1:0] usr_data_i,
  input wire [CHAN_W-1:0] usr_channel_i,
  input wire [ERR_W-1:0] usr_error_i,
  input wire [EMPTY_W-1:0] usr_empty_i,
  input wire usr_startofpacket_i,
  input wire usr_endofpacket_i,
  output reg usr_ready_o,
  output reg bad_channel_o,
  input wire snk_ready_i,
  output reg snk_valid_o,
  output reg [DATA_W-1:0] snk_data_o,
  output reg [CHAN_W-1:0] snk_channel_o,
  output reg [ERR_W-1:0] snk_error_o,
  output reg [EMPTY_W-1:0] snk_empty_o,
  output reg snk_startofpacket_o,
  output reg snk_endofpacket_o
);

  localparam WORD_W = DATA_W + CHAN_W + ERR_W + EMPTY_W + 2;
  localparam HIST_W = (READY_LATENCY > 1) ? READY_LATENCY - 1 : 1;
  localparam [CHAN_W-1:0] TOP_CHAN = HIGHEST_CHANNEL;

  reg [WORD_W-1:0] mem_reg [0:`SRC_FIFO_DEPTH-1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] count_reg;
  reg [1:0] count_next;
  reg [HIST_W-1:0] hist_reg;
  reg next_ready_cycle;
  reg load_out;
  wire push;
  wire pop;
  wire fifo_has_word;
  wire [EMPTY_W-1:0] empty_in;
  wire [WORD_W-1:0] word_in;
  wire [WORD_W-1:0] word_out;

  // Empty count only kept on end beats
  assign empty_in = usr_endofpacket_i ? usr_empty_i : {EMPTY_W{1'b0}};
  // Start and end may both ride one beat
  assign word_in = {usr_startofpacket_i, usr_endofpacket_i, empty_in,
                    usr_channel_i, usr_error_i, usr_data_i};
  assign push = usr_valid_i & usr_ready_o;
  assign fifo_has_word = (count_reg != 2'h0);
  assign word_out = mem_reg[rd_ptr_reg];
  assign pop = load_out & fifo_has_word;

  // Ready cycle prediction for the next clock
  always @* begin
    if (READY_LATENCY == 1) begin
      next_ready_cycle = snk_ready_i;
    end else begin
      next_ready_cycle = hist_reg[HIST_W-1];
    end
  end

  // Output stage load decision
  always @* begin
    if (READY_LATENCY == 0) begin
      load_out = ~snk_valid_o | snk_ready_i;
    end else begin
      load_out = next_ready_cycle;
    end
  end

  always @* begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'h1;
    end
  end

  // Ready history, one flop per latency cycle beyond the first
  generate
    if (HIST_W > 1) begin : g_hist_long
      always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          hist_reg <= {HIST_W{1'b0}};
        end else begin
          hist_reg <= {hist_reg[HIST_W-2:0], snk_ready_i};
        end
      end
    end else begin : g_hist_short
      always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          hist_reg <= {HIST_W{1'b0}};
        end else begin
          hist_reg <= {{(HIST_W-1){1'b0}}, snk_ready_i};
        end
      end
    end
  endgenerate

  // Two-entry buffer
  always @(posedge core_clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= word_in;
    end
  end

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_reg <= `SRC_PTR_RST;
      rd_ptr_reg <= `SRC_PTR_RST;
      count_reg <= `SRC_CNT_RST;
      usr_ready_o <= `SRC_FLAG_RST;
      bad_channel_o <= `SRC_FLAG_RST;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_next;
      usr_ready_o <= (count_next != 2'h2);
      // Channel beyond the highest setting is flagged sticky
      if (push && usr_channel_i > TOP_CHAN) begin
        bad_channel_o <= 1'b1;
      end
    end
  end

  // Link outputs, one role per port, all active high
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      snk_valid_o <= 1'b0;
      snk_data_o <= {DATA_W{1'b0}};
      snk_channel_o <= {CHAN_W{1'b0}};
      snk_error_o <= {ERR_W{1'b0}};
      snk_empty_o <= {EMPTY_W{1'b0}};
      snk_startofpacket_o <= 1'b0;
      snk_endofpacket_o <= 1'b0;
    end else if (load_out) begin
      // Valid qualifies the rest; idle beats carry no framing
      snk_valid_o <= fifo_has_word;
      if (fifo_has_word) begin
        snk_data_o <= word_out[DATA_W-1:0];
        snk_error_o <= word_out[DATA_W+ERR_W-1:DATA_W];
        snk_channel_o <=
          word_out[DATA_W+ERR_W+CHAN_W-1:DATA_W+ERR_W];
        snk_empty_o <= word_out[WORD_W-3:WORD_W-2-EMPTY_W];
        snk_endofpacket_o <= word_out[WORD_W-2];
        snk_startofpacket_o <= word_out[WORD_W-1];
      end else begin
        snk_startofpacket_o <= 1'b0;
        snk_endofpacket_o <= 1'b0;
      end
    end else if (READY_LATENCY != 0) begin
      // Not a ready cycle: valid must drop
      snk_valid_o <= 1'b0;
      snk_startofpacket_o <= 1'b0;
      snk_endofpacket_o <= 1'b0;
    end
  end

endmodule

// file: rtl/stream_source_defs.vh
// Constants for the streaming source controller
`ifndef STREAM_SOURCE_DEFS_VH
`define STREAM_SOURCE_DEFS_VH
`define SRC_DATA_W 32
`define SRC_CHAN_W 4
`define SRC_HIGHEST_CHANNEL 15
`define SRC_ERR_W 2
`define SRC_EMPTY_W 2
`define SRC_READY_LATENCY 1
`define SRC_FIFO_DEPTH 2
`define SRC_PTR_RST 1'h0
`define SRC_CNT_RST 2'h0
`define SRC_FLAG_RST 1'h0
`endif

// file: tb/sink_model.sv
// Sink model: paced ready and beat capture
module sink_model (
  input wire logic clk_i, slow_i, vld_i, eop_i, sop_i,
  input wire logic [3:0] chan_i,
  input wire logic [1:0] err_i,
  input wire logic [31:0] dat_i,
  input wire logic [1:0] emp_i,
  output logic rdy_o = 1'h0);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] q[$];
  logic [7:0] f[$];
  logic [1:0] last_emp = 2'h0;
  logic [1:0] n = 2'h0;
  always @(negedge clk_i) begin
    n <= n + 2'h1;
    rdy_o <= !slow_i || n[1];
  end
  always @(posedge clk_i) if (vld_i) begin
    q.push_back(dat_i);
    f.push_back({sop_i, eop_i, err_i, chan_i});
    if (eop_i) last_emp <= emp_i;
  end
endmodule

// file: tb/stream_source_props.sv
// Checker for the stream source link side
module stream_source_props #(parameter HC = 15) (
  input wire core_clk_i, rstn_i, usr_valid_i, usr_ready_o, snk_ready_i,
  input wire snk_valid_o, snk_startofpacket_o, snk_endofpacket_o,
  input wire bad_channel_o,
  input wire [3:0] usr_channel_i,
  input wire [1:0] snk_empty_o);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_VLD: assert property (snk_valid_o |-> $past(snk_ready_i))
    else $error("beat off ready cycle");
  AST_GO: assert property (usr_valid_i && usr_ready_o ##1 snk_ready_i
    |=> snk_valid_o) else $error("beat late");
  AST_NRDY: assert property ($fell(snk_ready_i) |=> !snk_valid_o)
    else $error("beat after ready drop");
  AST_SOP: assert property (snk_startofpacket_o |-> snk_valid_o)
    else $error("start without valid");
  AST_EOP: assert property (snk_endofpacket_o |-> snk_valid_o)
    else $error("end without valid");
  AST_EMP: assert property (snk_valid_o && !snk_endofpacket_o
    |-> snk_empty_o == 2'h0) else $error("empty off end beat");
  AST_BAD: assert property (usr_valid_i && usr_ready_o
    && usr_channel_i > HC |=> bad_channel_o) else $error("no bad flag");
  AST_STK: assert property (bad_channel_o |=> bad_channel_o)
    else $error("bad flag lost");
endmodule
bind stream_source stream_source_props #(.HC(HIGHEST_CHANNEL)) props (.*);

// file: tb/stream_source_tb.sv
// Self-checking bench for the stream source
module stream_source_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rstn = 1'h0, slow = 1'h0, uv = 1'h0, us, ue;
  logic [31:0] ud = 32'h0000_0000;
  logic [3:0] uc = 4'h0;
  logic [1:0] um;
  logic [31:0] exp_q[$];
  logic [7:0] exp_f[$];
  wire rdy, vld, eop, sop, uro, bad;
  wire [31:0] dat;
  wire [1:0] emp, er;
  wire [3:0] ch;
  int errors = 0, checks = 0, t;
  initial forever #12.5 clk = ~clk;
  stream_source #(.HIGHEST_CHANNEL(9)) dut (.core_clk_i(clk), .rstn_i(rstn),
    .usr_valid_i(uv), .usr_data_i(ud), .usr_channel_i(uc),
    .usr_error_i(ud[1:0]), .usr_empty_i(um), .usr_startofpacket_i(us),
    .usr_endofpacket_i(ue), .usr_ready_o(uro), .bad_channel_o(bad),
    .snk_ready_i(rdy), .snk_valid_o(vld), .snk_data_o(dat),
    .snk_channel_o(ch), .snk_error_o(er), .snk_empty_o(emp),
    .snk_startofpacket_o(sop), .snk_endofpacket_o(eop));
  sink_model sink (.clk_i(clk), .slow_i(slow), .vld_i(vld), .eop_i(eop),
    .sop_i(sop), .chan_i(ch), .err_i(er),
    .dat_i(dat), .emp_i(emp), .rdy_o(rdy));
  task chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task push(input logic [31:0] d, input logic [3:0] c, input logic s, e);
    for (t = 0; uro !== 1'h1 && t < 64; t++) @(negedge clk);
    chk(uro, 1'h1);
    {ud, uc, us, ue, um, uv} = {d, c, s, e, e ? 2'h3 : 2'h0, 1'h1};
    exp_q.push_back(d);
    exp_f.push_back({s, e, d[1:0], c});
    @(negedge clk);
  endtask
  task drain;
    uv = 1'h0;
    for (t = 0; sink.q.size() < exp_q.size() && t < 99; t++) @(negedge clk);
    chk(sink.q.size(), exp_q.size());
    while (exp_q.size()) chk(sink.q.pop_front(), exp_q.pop_front());
    chk(sink.f.size(), exp_f.size());
    while (exp_f.size()) chk(sink.f.pop_front(), exp_f.pop_front());
  endtask
  task t_fast;
    push(32'hA0A0_0001, 4'h1, 1'h1, 1'h0);
    push(32'hA0A0_0002, 4'h2, 1'h0, 1'h1);
    push(32'hB0B0_0003, 4'h3, 1'h1, 1'h1);
    drain;
    chk(sink.last_emp, 2'h3);
    chk(bad, 1'h0);
  endtask
  task t_stall;
    slow = 1'h1;
    for (int i = 0; i < 7; i++) push(32'hC0C0_0000 + i, 4'h9, 1'h0, 1'h0);
    drain;
    slow = 1'h0;
  endtask
  task t_bad;
    push(32'hD0D0_0004, 4'hA, 1'h1, 1'h1);
    drain;
    chk(bad, 1'h1);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rstn = 1'h1;
    t_fast;
    t_stall;
    t_bad;
    give_verdict;
  end
  initial begin
    #100us;
    errors++;
    give_verdict;
  end
endmodule
